/* ctms_map.vh */
// Register map, field positions and reset values of the transmit mailbox status block
`ifndef CTMS_MAP_VH
`define CTMS_MAP_VH
`define CTMS_ADDR_STATUS 12'h008
`define CTMS_ADDR_IRQ_STAT 12'h020
`define CTMS_ADDR_IRQ_MASK 12'h024
`define CTMS_ADDR_REQUEST 12'h028
`define CTMS_GRP_W 8
`define CTMS_F_DONE 0
`define CTMS_F_OK 1
`define CTMS_F_ALST 2
`define CTMS_F_ERR 3
`define CTMS_F_ABORT 7
`define CTMS_F_CODE_LO 24
`define CTMS_F_EMPTY_LO 26
`define CTMS_F_LOW_LO 29
`define CTMS_RESET_STATUS 32'h1C00_0000
`define CTMS_ZERO32 32'h0000_0000
`define CTMS_IRQ_W 3
`endif

/* ctms_prio.v */
// Lowest-priority pick and next-free mailbox code for three mailboxes
`timescale 1ns/1ns
`default_nettype none
module ctms_prio (
  input wire [2:0] pend, // Mailboxes waiting to send
  input wire [2:0] prio_low, // Mailboxes ranked lowest by the engine
  output reg [2:0] low_flags, // Lowest-priority flags
  output reg [1:0] code // Next empty or lowest-priority mailbox
);
  reg [1:0] low_idx;
  reg [1:0] rank_idx;
  reg multi;

  // Flags only mean something with two or more mailboxes waiting
  always @* begin
    multi = (pend[0] & pend[1]) | (pend[0] & pend[2]) | (pend[1] & pend[2]);
    // Engine ranking alone, used for the code while nothing waits
    rank_idx = 2'd0;
    if (prio_low[2]) begin
      rank_idx = 2'd2;
    end else if (prio_low[1]) begin
      rank_idx = 2'd1;
    end
    // A ranking that names an idle mailbox must never flag it, so the
    // highest-numbered waiting mailbox stands in for it
    low_idx = 2'd0;
    if (pend[2]) begin
      low_idx = 2'd2;
    end else if (pend[1]) begin
      low_idx = 2'd1;
    end
    if (prio_low[0] && pend[0]) begin
      low_idx = 2'd0;
    end else if (prio_low[1] && pend[1]) begin
      low_idx = 2'd1;
    end else if (prio_low[2] && pend[2]) begin
      low_idx = 2'd2;
    end
    low_flags = 3'b000;
    if (multi) begin
      low_flags[low_idx] = 1'b1;
    end
    if (pend == 3'b000) begin
      code = rank_idx;
    end else if (!pend[0]) begin
      code = 2'd0;
    end else if (!pend[1]) begin
      code = 2'd1;
    end else if (!pend[2]) begin
      code = 2'd2;
    end else begin
      code = low_idx;
    end
  end
endmodule // ctms_prio
`default_nettype wire

/* ctms_slot.v */
// Per-mailbox pending, abort and completion flag logic
`timescale 1ns/1ns
`default_nettype none
module ctms_slot (
  input wire pclk, // Bus clock
  input wire presetn, // Async reset, active low
  input wire req_set, // Software raises a transmit request
  input wire abort_wr, // Software writes 1 to the abort bit
  input wire done_wr1, // Software writes 1 to request-complete
  input wire eng_done, // Engine: attempt or abort finished
  input wire eng_ok, // Engine: finished attempt succeeded
  input wire eng_err, // Engine: failed by bus error
  input wire eng_alst, // Engine: failed by lost arbitration
  output reg pend_reg, // Message waiting to be sent
  output reg abort_reg, // Abort request pending
  output reg done_reg, // Request complete
  output reg ok_reg, // Last attempt succeeded
  output reg alst_reg, // Arbitration lost
  output reg err_reg // Transmission error
);
  reg pend_next;
  reg abort_next;
  reg done_next;
  reg ok_next;
  reg alst_next;
  reg err_next;
  wire clr_done;
  wire finish;

  // A finished request (sent, or aborted) leaves the mailbox idle
  assign finish = pend_reg & (eng_done | abort_reg);
  // Clear causes; the hardware set below takes precedence
  assign clr_done = done_wr1 | req_set;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always @* begin
    pend_next = pend_reg;
    abort_next = abort_reg;
    done_next = done_reg;
    ok_next = ok_reg;
    alst_next = alst_reg;
    err_next = err_reg;
    if (clr_done) begin
      done_next = 1'b0;
      ok_next = 1'b0;
      alst_next = 1'b0;
      err_next = 1'b0;
    end
    if (abort_wr && pend_reg) begin
      abort_next = 1'b1;
    end
    if (finish) begin
      pend_next = 1'b0;
      abort_next = 1'b0;
      done_next = 1'b1;
    end
    if (pend_reg && eng_done && !abort_reg) begin
      ok_next = eng_ok;
      err_next = eng_err | (err_reg & ~clr_done);
      alst_next = eng_alst | (alst_reg & ~clr_done);
    end
    if (req_set && !pend_reg) begin
      pend_next = 1'b1;
    end
  end

  // Flag storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      abort_reg <= 1'b0;
      done_reg <= 1'b0;
      ok_reg <= 1'b0;
      alst_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      abort_reg <= abort_next;
      done_reg <= done_next;
      ok_reg <= ok_next;
      alst_reg <= alst_next;
      err_reg <= err_next;
    end
  end
endmodule // ctms_slot
`default_nettype wire

/* ctms_top.v */
// APB slave for the transmit mailbox status register with interrupt
`timescale 1ns/1ns
`default_nettype none
`include "ctms_map.vh"
module ctms_top #(
  parameter NSLOT = 3 // Mailbox count
) (
  input wire pclk, // Bus clock, 20 MHz
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction, 1 = write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error, unmapped address
  input wire [2:0] eng_done, // Engine: attempt or abort finished
  input wire [2:0] eng_ok, // Engine: attempt succeeded
  input wire [2:0] eng_err, // Engine: bus error
  input wire [2:0] eng_alst, // Engine: arbitration lost
  input wire [2:0] eng_prio_low, // Engine: lowest-priority ranking
  output reg [2:0] eng_pend, // To engine: mailbox waiting to send
  output reg [2:0] eng_abort, // To engine: abort requested
  output reg irq // Interrupt, level, active high
);
  wire [2:0] pend;
  wire [2:0] abrt;
  wire [2:0] done;
  wire [2:0] ok;
  wire [2:0] alst;
  wire [2:0] err;
  wire [2:0] low_flags;
  wire [1:0] code;
  wire [2:0] req_set;
  wire [2:0] abort_wr;
  wire [2:0] done_wr1;
  wire [2:0] done_rise;
  wire setup;
  wire wr;
  wire hit_stat;
  wire hit_ist;
  wire hit_msk;
  wire hit_req;
  wire mapped;
  reg [2:0] done_d_reg;
  reg [2:0] ist_reg;
  reg [2:0] ist_next;
  reg [2:0] msk_reg;
  reg [31:0] status;
  reg [31:0] rd_next;
  integer j;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: one wait-free access, answered in the access phase.
  // Writes land at the access edge, where the master sees pready high,
  // so a transfer that the master never completes changes nothing
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;
  assign hit_stat = (paddr == `CTMS_ADDR_STATUS);
  assign hit_ist = (paddr == `CTMS_ADDR_IRQ_STAT);
  assign hit_msk = (paddr == `CTMS_ADDR_IRQ_MASK);
  assign hit_req = (paddr == `CTMS_ADDR_REQUEST);
  assign mapped = hit_stat | hit_ist | hit_msk | hit_req;

  ////////////////////////////////////////////////////////////////////////
  // Mailbox slices, identical per mailbox
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : g_slot
      // Abort and done strobes pick the slice's own byte group; the request strobe takes bit g
      assign req_set[g] = wr & hit_req & pwdata[g];
      assign abort_wr[g] = wr & hit_stat &
        pwdata[g*`CTMS_GRP_W + `CTMS_F_ABORT];
      assign done_wr1[g] = wr & hit_stat &
        pwdata[g*`CTMS_GRP_W + `CTMS_F_DONE];
      assign done_rise[g] = done[g] & ~done_d_reg[g];
      ctms_slot u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .req_set(req_set[g]),
        .abort_wr(abort_wr[g]),
        .done_wr1(done_wr1[g]),
        .eng_done(eng_done[g]),
        .eng_ok(eng_ok[g]),
        .eng_err(eng_err[g]),
        .eng_alst(eng_alst[g]),
        .pend_reg(pend[g]),
        .abort_reg(abrt[g]),
        .done_reg(done[g]),
        .ok_reg(ok[g]),
        .alst_reg(alst[g]),
        .err_reg(err[g])
      );
    end
  endgenerate

  // Priority pick and mailbox code
  ctms_prio u_prio (
    .pend(pend),
    .prio_low(eng_prio_low),
    .low_flags(low_flags),
    .code(code)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status word; bits not assigned, including 22:20, stay zero
  always @* begin
    status = `CTMS_ZERO32;
    for (j = 0; j < NSLOT; j = j + 1) begin
      status[j*`CTMS_GRP_W + `CTMS_F_DONE] = done[j];
      status[j*`CTMS_GRP_W + `CTMS_F_OK] = ok[j];
      status[j*`CTMS_GRP_W + `CTMS_F_ALST] = alst[j];
      status[j*`CTMS_GRP_W + `CTMS_F_ERR] = err[j];
      status[j*`CTMS_GRP_W + `CTMS_F_ABORT] = abrt[j];
      status[`CTMS_F_EMPTY_LO + j] = ~pend[j];
      status[`CTMS_F_LOW_LO + j] = low_flags[j];
    end
    status[`CTMS_F_CODE_LO +: 2] = code;
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_next = `CTMS_ZERO32;
    if (hit_stat) begin
      rd_next = status;
    end else if (hit_ist) begin
      rd_next[`CTMS_IRQ_W-1:0] = ist_reg;
    end else if (hit_msk) begin
      rd_next[`CTMS_IRQ_W-1:0] = msk_reg;
    end else if (hit_req) begin
      rd_next[`CTMS_IRQ_W-1:0] = pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status: completion events set, write 1 clears,
  // and a set in the same cycle as its clear wins so no event is lost
  always @* begin
    ist_next = ist_reg;
    if (wr && hit_ist) begin
      ist_next = ist_reg & ~pwdata[`CTMS_IRQ_W-1:0];
    end
    ist_next = ist_next | done_rise;
  end

  // Registers, bus answer and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `CTMS_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
      done_d_reg <= 3'b000;
      ist_reg <= 3'b000;
      msk_reg <= 3'b000;
      eng_pend <= 3'b000;
      eng_abort <= 3'b000;
      irq <= 1'b0;
    end else begin
      // Ready raised for the access phase only
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata <= rd_next;
      end
      if (wr && hit_msk) begin
        msk_reg <= pwdata[`CTMS_IRQ_W-1:0];
      end
      done_d_reg <= done;
      ist_reg <= ist_next;
      eng_pend <= pend;
      eng_abort <= abrt;
      irq <= |(ist_next & msk_reg);
    end
  end
endmodule // ctms_top
`default_nettype wire

/* ctms_top_properties.sv */
// Port-level assertions for the transmit mailbox status block
`timescale 1ns/1ns
`default_nettype none
module ctms_top_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [2:0] eng_done, // Finished
  input wire logic [2:0] eng_ok, // Success
  input wire logic [2:0] eng_err, // Bus error
  input wire logic [2:0] eng_alst, // Lost
  input wire logic [2:0] eng_prio_low, // Ranking
  input wire logic [2:0] eng_pend, // Pending
  input wire logic [2:0] eng_abort, // Abort
  input wire logic irq // Interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup and access cycles; writes land at the access edge
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire st_rd = pready && !pwrite && paddr == 12'h008;
  wire st_wr = acc && pwrite && paddr == 12'h008 && pwdata[7];
  ////////////////////////////////////////////////////////////////////////////
  a_ready_one: assert property (setup |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_unmapped_err: assert property (setup && paddr == 12'h004 |=> pslverr)
    else $error("unmapped access not refused");
  a_empty_track: assert property (st_rd |-> prdata[28:26] == ~eng_pend)
    else $error("empty flags disagree with pending");
  a_code_free: assert property (st_rd && eng_pend != 3'b111 |->
    prdata[25:24] != 2'd3 && !eng_pend[prdata[25:24]])
    else $error("code does not name an empty mailbox");
  a_rsvd_zero: assert property (st_rd |-> prdata[22:20] == 3'b000)
    else $error("reserved bits not zero");
  a_low_single: assert property (st_rd && $countones(eng_pend) < 2 |->
    prdata[31:29] == 3'b000)
    else $error("lowest flags set with one waiting");
  a_low_many: assert property (st_rd && $countones(eng_pend) > 1 |->
    $onehot(prdata[31:29]) && (prdata[31:29] & ~eng_pend) == 3'b000)
    else $error("lowest flag not on one waiting mailbox");
  a_req_pends: assert property (acc && pwrite && paddr == 12'h028 &&
    pwdata[0] && !eng_done[0] |-> ##[1:2] eng_pend[0])
    else $error("request did not make mailbox pending");
  a_abort_drops: assert property (st_wr && eng_pend[0] |-> ##[1:3] !eng_pend[0])
    else $error("abort did not cancel request");
  a_abort_idle: assert property (st_wr && !eng_pend[0] |=> !eng_abort[0] [*3])
    else $error("abort took effect on empty mailbox");
  a_abort_clears: assert property ($rose(eng_abort[0]) |-> ##[1:3] !eng_abort[0])
    else $error("abort bit not cleared");
  // Main scenarios reached
  c_two_wait: cover property (st_rd && $countones(eng_pend) > 1);
  c_abort: cover property (st_wr && eng_pend[0]);
  c_irq_drop: cover property ($fell(irq));
endmodule // ctms_top_properties
bind ctms_top ctms_top_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .eng_done(eng_done), .eng_ok(eng_ok), .eng_err(eng_err),
  .eng_alst(eng_alst), .eng_prio_low(eng_prio_low), .eng_pend(eng_pend),
  .eng_abort(eng_abort), .irq(irq));
`default_nettype wire

/* ctms_top_tb.sv */
// Self-checking bench for the transmit mailbox status block
`timescale 1ns/1ns
`default_nettype none
module ctms_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] eng_done, eng_ok, eng_err, eng_alst, eng_prio_low;
  logic [2:0] eng_pend, eng_abort;
  logic [7:0] res [3] = '{8'h03, 8'h09, 8'h05}; // Ok, error, lost
  int fail_count = 0;
  int cmp_count = 0;
  localparam logic [31:0] M = 32'hFCFF_FFFF; // Code field left to checker
  ctms_top u_ctms_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eng_done(eng_done), .eng_ok(eng_ok), .eng_err(eng_err),
    .eng_alst(eng_alst), .eng_prio_low(eng_prio_low),
    .eng_pend(eng_pend), .eng_abort(eng_abort), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; idle cycle after so psel never toggles in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdst;
    apb(1'b0, 12'h008, 32'h0);
  endtask
  // Engine finishes the masked mailboxes with outcome r
  task fin(input logic [2:0] m, input logic [7:0] r);
    eng_done <= m;
    eng_ok <= r[1] ? m : 3'b000;
    eng_alst <= r[2] ? m : 3'b000;
    eng_err <= r[3] ? m : 3'b000;
    @(posedge pclk);
    eng_done <= 3'b000;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {eng_done, eng_ok, eng_err, eng_alst, eng_prio_low} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdst;
    chk("reset", rd, 32'h1C00_0000);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    rdst;
    chk("ro write", rd, 32'h1C00_0000);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped", {31'd0, er}, 32'h0000_0001);
    eng_prio_low <= 3'b100;
    rdst;
    chk("code idle", rd, 32'h1E00_0000);
    apb(1'b1, 12'h024, 32'h0000_0006);
    for (int g = 0; g < 3; g++) begin
      eng_prio_low <= 3'b001 << g;
      apb(1'b1, 12'h028, 32'h1 << g);
      rdst;
      chk("pending", rd & M, 32'h1C00_0000 ^ (32'h0400_0000 << g));
      chk("next free", {30'd0, rd[25:24]}, (g == 0) ? 32'h1 : 32'h0);
      fin(3'b001 << g, res[g]);
      apb(1'b1, 12'h008, 32'h0);
      rdst;
      chk("outcome", rd & M, 32'h1C00_0000 | ({24'd0, res[g]} << 8 * g));
      chk("irq", {31'd0, irq}, {31'd0, g != 0});
      apb(1'b1, 12'h020, 32'h0000_0007);
      apb(1'b1, 12'h008, 32'h1 << 8 * g);
      rdst;
      chk("cleared", rd & M, 32'h1C00_0000);
      chk("irq clear", {31'd0, irq}, 32'h0);
    end
    eng_prio_low <= 3'b001;
    apb(1'b1, 12'h028, 32'h0000_0003);
    rdst;
    chk("two wait", rd & M, 32'h3000_0000);
    apb(1'b1, 12'h008, 32'h0000_0080);
    rdst;
    chk("abort", rd & M, 32'h1400_0001);
    apb(1'b1, 12'h028, 32'h0000_0001);
    rdst;
    chk("rerequest", rd & M, 32'h3000_0000);
    eng_prio_low <= 3'b010;
    rdst;
    chk("two wait b", rd & M, 32'h5000_0000);
    fin(3'b011, 8'h03);
    apb(1'b1, 12'h008, 32'h0000_0101);
    rdst;
    chk("both done", rd & M, 32'h1C00_0000);
    print_verdict;
  end
  // Watchdog well past the about 120 cycles the tests need
  initial begin
    repeat (3000) @(posedge pclk);
    fail_count++;
    print_verdict;
  end
endmodule // ctms_top_tb
`default_nettype wire
